/* File: timer_pkg.sv */
package timer_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_MATCH = 4;
  localparam int NUM_CAP   = 3;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int MCR_W     = 12;
  localparam int CCR_W     = 13;
  localparam int ACT_W     = 8;
  localparam int STAT_W    = 7;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TC     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PR     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PC     = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MCR    = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CCR    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EMR    = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_PWMC   = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_MATCH0 = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CAP0   = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3C;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h40;
  localparam int                ADDR_STEP   = 4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_EXT_BIT  = 2;
  localparam int MCR_STRIDE    = 3;
  localparam int MCR_INT_OFS   = 0;
  localparam int MCR_RST_OFS   = 1;
  localparam int MCR_STOP_OFS  = 2;
  localparam int CCR_STRIDE    = 3;
  localparam int CCR_RISE_OFS  = 0;
  localparam int CCR_FALL_OFS  = 1;
  localparam int CCR_INT_OFS   = 2;
  localparam int CCR_CLR_EN    = 9;
  localparam int CCR_CLR_SEL   = 10;
  localparam int CCR_CLR_FALL  = 12;
  localparam int EMR_ACT_LSB   = 4;
  localparam int STAT_CAP_LSB  = 4;

  // ---------------------------------------------------------------
  // Match output actions
  // ---------------------------------------------------------------
  typedef logic [1:0] act_type;
  localparam act_type ACT_NONE   = 2'h0;
  localparam act_type ACT_LOW    = 2'h1;
  localparam act_type ACT_HIGH   = 2'h2;
  localparam act_type ACT_TOGGLE = 2'h3;

  // ---------------------------------------------------------------
  // Block state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                              enable;
    logic                              hold;
    logic                              ext_mode;
    logic [DATA_W-1:0]                 tc;
    logic [DATA_W-1:0]                 pc;
    logic [DATA_W-1:0]                 pr;
    logic [MCR_W-1:0]                  mcr;
    logic [CCR_W-1:0]                  ccr;
    logic [ACT_W-1:0]                  emr_act;
    logic [NUM_MATCH-1:0]              mout;
    logic [NUM_MATCH-1:0]              pwm;
    logic [NUM_MATCH-1:0][DATA_W-1:0]  shadow;
    logic [NUM_MATCH-1:0][DATA_W-1:0]  active;
    logic [NUM_CAP-1:0][DATA_W-1:0]    cap;
    logic [STAT_W-1:0]                 status;
    logic [STAT_W-1:0]                 mask;
    logic                              ext_prev;
    logic [NUM_CAP-1:0]                cap_prev;
    logic [DATA_W-1:0]                 rdata;
    logic                              irq;
  } state_type;

endpackage

/* File: timer_capture_match_pwm.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_capture_match_pwm
  import timer_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic                 ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [DATA_W-1:0]    rdata_o,
  // Pins
  input  wire logic                 ext_count_i,
  input  wire logic [NUM_CAP-1:0]   cap_i,
  output logic      [NUM_MATCH-1:0] match_o,
  // Interrupt
  output logic                      irq_o
);

  state_type             s_ff;
  state_type             nxt_s;
  logic                  ext_edge;
  logic                  run_step;
  logic                  tick;
  logic [NUM_MATCH-1:0]  match_ev;
  logic [NUM_MATCH-1:0]  rst_sel;
  logic [NUM_MATCH-1:0]  stop_sel;
  logic                  period_rst;
  logic [NUM_CAP-1:0]    cap_rise;
  logic [NUM_CAP-1:0]    cap_fall;
  logic [NUM_CAP-1:0]    cap_ev;
  logic                  cap_clr;
  logic                  wr_tc;
  logic                  wr_pc;
  logic                  wr_ctrl;
  logic                  wr_emr;
  logic [STAT_W-1:0]     stat_set;
  logic [STAT_W-1:0]     stat_clr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s    = s_ff;
    stat_set = '0;
    stat_clr = '0;
    wr_tc    = wr_i && (addr_i == ADDR_TC);
    wr_pc    = wr_i && (addr_i == ADDR_PC);
    wr_ctrl  = wr_i && (addr_i == ADDR_CTRL);
    wr_emr   = wr_i && (addr_i == ADDR_EMR);

    // Count source and prescaler terminal count
    ext_edge = ext_count_i & ~s_ff.ext_prev;
    run_step = s_ff.enable & ~s_ff.hold & (s_ff.ext_mode ? ext_edge : 1'b1);
    tick     = run_step & (s_ff.pc == s_ff.pr);

    for (int i = 0; i < NUM_MATCH; i++) begin
      match_ev[i] = tick & (s_ff.tc == s_ff.active[i]);
      rst_sel[i]  = s_ff.mcr[MCR_STRIDE*i + MCR_RST_OFS];
      stop_sel[i] = s_ff.mcr[MCR_STRIDE*i + MCR_STOP_OFS];
      stat_set[i] = match_ev[i] & s_ff.mcr[MCR_STRIDE*i + MCR_INT_OFS];
    end
    period_rst = |(match_ev & rst_sel);

    // Capture edges, judged against the previous sample of each pin
    for (int c = 0; c < NUM_CAP; c++) begin
      cap_rise[c] = cap_i[c] & ~s_ff.cap_prev[c];
      cap_fall[c] = ~cap_i[c] & s_ff.cap_prev[c];
      cap_ev[c]   = (cap_rise[c] & s_ff.ccr[CCR_STRIDE*c + CCR_RISE_OFS])
                  | (cap_fall[c] & s_ff.ccr[CCR_STRIDE*c + CCR_FALL_OFS]);
      stat_set[STAT_CAP_LSB + c] = cap_ev[c] & s_ff.ccr[CCR_STRIDE*c + CCR_INT_OFS];
      if (cap_ev[c]) begin
        nxt_s.cap[c] = s_ff.tc;
      end
    end
    // Selector code 3 names no channel and never clears
    cap_clr = 1'b0;
    if (s_ff.ccr[CCR_CLR_EN] && (s_ff.ccr[CCR_CLR_SEL +: 2] < 2'(NUM_CAP))) begin
      cap_clr = s_ff.ccr[CCR_CLR_FALL] ? cap_fall[s_ff.ccr[CCR_CLR_SEL +: 2]]
                                       : cap_rise[s_ff.ccr[CCR_CLR_SEL +: 2]];
    end

    // Prescaler and counter
    if (run_step) begin
      nxt_s.pc = tick ? '0 : s_ff.pc + 32'h0000_0001;
    end
    if (tick) begin
      nxt_s.tc = period_rst ? '0 : s_ff.tc + 32'h0000_0001;
    end
    if (|(match_ev & stop_sel)) begin
      nxt_s.enable = 1'b0;
    end
    if (cap_clr || s_ff.hold) begin
      nxt_s.tc = '0;
      nxt_s.pc = '0;
    end

    // Match outputs: PWM channels drop at the period start and rise on their match
    for (int i = 0; i < NUM_MATCH; i++) begin
      if (s_ff.pwm[i] && period_rst) begin
        nxt_s.mout[i] = 1'b0;
      end
      if (match_ev[i]) begin
        if (s_ff.pwm[i]) begin
          nxt_s.mout[i] = 1'b1;
        end else begin
          unique case (s_ff.emr_act[2*i +: 2])
            ACT_NONE:   nxt_s.mout[i] = s_ff.mout[i];
            ACT_LOW:    nxt_s.mout[i] = 1'b0;
            ACT_HIGH:   nxt_s.mout[i] = 1'b1;
            ACT_TOGGLE: nxt_s.mout[i] = ~s_ff.mout[i];
          endcase
        end
      end
      // Only a period boundary may move a PWM compare, so a late write cannot split a pulse
      if (!s_ff.pwm[i] || period_rst) begin
        nxt_s.active[i] = s_ff.shadow[i];
      end
    end

    // Register writes win over the counting logic
    if (wr_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          nxt_s.enable   = wdata_i[CTRL_EN_BIT];
          nxt_s.hold     = wdata_i[CTRL_HOLD_BIT];
          nxt_s.ext_mode = wdata_i[CTRL_EXT_BIT];
        end
        ADDR_TC:     nxt_s.tc      = wdata_i;
        ADDR_PR:     nxt_s.pr      = wdata_i;
        ADDR_PC:     nxt_s.pc      = wdata_i;
        ADDR_MCR:    nxt_s.mcr     = wdata_i[MCR_W-1:0];
        ADDR_CCR:    nxt_s.ccr     = wdata_i[CCR_W-1:0];
        ADDR_EMR: begin
          nxt_s.mout    = wdata_i[NUM_MATCH-1:0];
          nxt_s.emr_act = wdata_i[EMR_ACT_LSB +: ACT_W];
        end
        ADDR_PWMC:   nxt_s.pwm     = wdata_i[NUM_MATCH-1:0];
        ADDR_STATUS: stat_clr      = wdata_i[STAT_W-1:0];
        ADDR_MASK:   nxt_s.mask    = wdata_i[STAT_W-1:0];
        default: begin
          for (int i = 0; i < NUM_MATCH; i++) begin
            if (addr_i == ADDR_W'(ADDR_MATCH0 + ADDR_STEP*i)) begin
              nxt_s.shadow[i] = wdata_i;
            end
          end
        end
      endcase
    end

    // A new event outlives a write-one-to-clear in the same cycle
    nxt_s.status = (s_ff.status & ~stat_clr) | stat_set;
    nxt_s.irq    = |(nxt_s.status & nxt_s.mask);

    // Read data stands only in the cycle after the strobe
    nxt_s.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL:   nxt_s.rdata = DATA_W'({s_ff.ext_mode, s_ff.hold, s_ff.enable});
        ADDR_TC:     nxt_s.rdata = s_ff.tc;
        ADDR_PR:     nxt_s.rdata = s_ff.pr;
        ADDR_PC:     nxt_s.rdata = s_ff.pc;
        ADDR_MCR:    nxt_s.rdata = DATA_W'(s_ff.mcr);
        ADDR_CCR:    nxt_s.rdata = DATA_W'(s_ff.ccr);
        ADDR_EMR:    nxt_s.rdata = DATA_W'({s_ff.emr_act, s_ff.mout});
        ADDR_PWMC:   nxt_s.rdata = DATA_W'(s_ff.pwm);
        ADDR_STATUS: nxt_s.rdata = DATA_W'(s_ff.status);
        ADDR_MASK:   nxt_s.rdata = DATA_W'(s_ff.mask);
        default: begin
          for (int i = 0; i < NUM_MATCH; i++) begin
            if (addr_i == ADDR_W'(ADDR_MATCH0 + ADDR_STEP*i)) begin
              nxt_s.rdata = s_ff.shadow[i];
            end
          end
          for (int c = 0; c < NUM_CAP; c++) begin
            if (addr_i == ADDR_W'(ADDR_CAP0 + ADDR_STEP*c)) begin
              nxt_s.rdata = s_ff.cap[c];
            end
          end
        end
      endcase
    end

    nxt_s.ext_prev = ext_count_i;
    nxt_s.cap_prev = cap_i;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_ff <= '0;
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rdata;
  assign match_o = s_ff.mout;
  assign irq_o   = s_ff.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  count_step_a: assert property (
    ce_i && tick && !period_rst && !cap_clr && !wr_tc && !wr_pc
    |=> s_ff.tc == $past(s_ff.tc) + 32'h0000_0001 && s_ff.pc == '0)
    else $error("counter did not step on prescaler terminal count");

  ext_hold_a: assert property (
    ce_i && s_ff.ext_mode && !ext_edge && !cap_clr && !s_ff.hold && !wr_tc && !wr_pc
    |=> $stable(s_ff.tc) && $stable(s_ff.pc))
    else $error("counter moved without an external count edge");

  capture_load_a: assert property (
    ce_i && cap_ev[0] |=> s_ff.cap[0] == $past(s_ff.tc))
    else $error("capture register missed the counter value");

  match_flag_a: assert property (
    ce_i && match_ev[0] && s_ff.mcr[MCR_INT_OFS] |=> s_ff.status[0])
    else $error("match interrupt flag not raised");

  match_stop_a: assert property (
    ce_i && |(match_ev & stop_sel) && !wr_ctrl |=> !s_ff.enable)
    else $error("stop on match did not halt the counter");

  match_reset_a: assert property (
    ce_i && period_rst && !wr_tc |=> s_ff.tc == '0)
    else $error("reset on match did not zero the counter");

  shadow_hold_a: assert property (
    ce_i && s_ff.pwm[1] && !period_rst |=> $stable(s_ff.active[1]))
    else $error("PWM compare changed inside a period");

  match_toggle_a: assert property (
    ce_i && match_ev[2] && !s_ff.pwm[2] && !wr_emr
      && s_ff.emr_act[2*2 +: 2] == ACT_TOGGLE
    |=> match_o[2] != $past(match_o[2]))
    else $error("match output did not toggle");

  capture_clear_a: assert property (
    ce_i && cap_clr && !wr_tc && !wr_pc |=> s_ff.tc == '0 && s_ff.pc == '0)
    else $error("capture clear left counter or prescaler running");

  pwm_edge_a: assert property (
    ce_i && match_ev[1] && s_ff.pwm[1] && !wr_emr |=> match_o[1])
    else $error("PWM output did not rise on its match");

  irq_level_a: assert property (
    irq_o == |(s_ff.status & s_ff.mask))
    else $error("interrupt output disagrees with status and mask");

  period_seen_c:  cover property (ce_i && period_rst && |s_ff.pwm);
  capture_seen_c: cover property (ce_i && cap_clr);
  stop_seen_c:    cover property (ce_i && |(match_ev & stop_sel));

endmodule

`default_nettype wire

/* File: timer_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Pin side: count clock and capture sources
// ---------------------------------------------------------------
module timer_pins_model
  import timer_pkg::*;
(
  // Clock
  input  wire logic               clock_i,
  // Pins
  output logic                    ext_count_o,
  output logic      [NUM_CAP-1:0] cap_o
);
  initial begin
    ext_count_o = 1'h0;
    cap_o       = '0;
  end

  // Count clock stands low outside bursts
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clock_i) ext_count_o <= 1'h1;
      @(posedge clock_i) ext_count_o <= 1'h0;
    end
  endtask

  // Levels are held a few cycles so the edge detector sees each one
  task automatic cap_set(input logic [NUM_CAP-1:0] v);
    @(posedge clock_i) cap_o <= v;
    repeat (3) @(posedge clock_i);
  endtask
endmodule

`default_nettype wire

/* File: test_timer_capture_match_pwm.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_timer_capture_match_pwm
  import timer_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic                 clock_i;
  logic                 srst_i;
  logic                 ce_i;
  logic [ADDR_W-1:0]    addr_i;
  logic [DATA_W-1:0]    wdata_i;
  logic                 wr_i;
  logic                 rd_i;
  logic [DATA_W-1:0]    rdata_o;
  logic                 ext_count;
  logic [NUM_CAP-1:0]   cap;
  logic [NUM_MATCH-1:0] match_o;
  logic                 irq_o;
  int                   n_checks;
  int                   mismatches;

  timer_capture_match_pwm u_timer_capture_match_pwm (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_count_i(ext_count), .cap_i(cap), .match_o(match_o), .irq_o(irq_o)
  );

  timer_pins_model u_timer_pins_model (
    .clock_i(clock_i), .ext_count_o(ext_count), .cap_o(cap)
  );

  always #20 clock_i = ~clock_i;

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 `CHK(nm, e, rdata_o)
  endtask

  task automatic rst();
    @(posedge clock_i);
    srst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'h0;
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clock_i);
    #1 `CHK("irq", e, irq_o)
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    wr(8'h44, 32'hFFFF_FFFF);
    wr(ADDR_CAP0, 32'h0000_00AA);
    rchk("unmapped", 8'h44, 32'h0);
    rchk("cap0 ro", ADDR_CAP0, 32'h0);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    rchk("status", ADDR_STATUS, 32'h0);
    `CHK("match_o", 4'h0, match_o)
    $display("test reset done");
  endtask

  task automatic t_prescale();
    rst();
    wr(ADDR_PR, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    repeat (38) @(posedge clock_i);
    wr(ADDR_CTRL, 32'h0);
    rchk("tc", ADDR_TC, 32'hA);
    rchk("pc", ADDR_PC, 32'h0);
    $display("test prescale done");
  endtask

  task automatic t_match_reset();
    rst();
    wr(ADDR_MATCH0, 32'h5);
    wr(ADDR_MCR, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    repeat (13) @(posedge clock_i);
    wr(ADDR_CTRL, 32'h0);
    rchk("tc", ADDR_TC, 32'h3);
    rchk("status", ADDR_STATUS, 32'h1);
    irq_is(1'h0);
    wr(ADDR_MASK, 32'h1);
    irq_is(1'h1);
    wr(ADDR_STATUS, 32'h1);
    irq_is(1'h0);
    $display("test match reset done");
  endtask

  task automatic t_continue();
    rst();
    wr(ADDR_MATCH0, 32'h2);
    wr(ADDR_MCR, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    repeat (8) @(posedge clock_i);
    wr(ADDR_CTRL, 32'h0);
    rchk("tc", ADDR_TC, 32'hA);
    rchk("status", ADDR_STATUS, 32'h1);
    $display("test continue done");
  endtask

  task automatic t_stop();
    rst();
    wr(ADDR_MATCH0, 32'h4);
    wr(ADDR_MCR, 32'h4);
    wr(ADDR_CTRL, 32'h1);
    repeat (18) @(posedge clock_i);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    rchk("tc", ADDR_TC, 32'h5);
    rchk("status", ADDR_STATUS, 32'h0);
    $display("test stop done");
  endtask

  task automatic t_outputs();
    rst();
    wr(ADDR_EMR, 32'h0000_0E43);
    #1 `CHK("preset", 4'h3, match_o)
    for (int i = 0; i < NUM_MATCH; i++) begin
      wr(ADDR_MATCH0 + 8'(ADDR_STEP * i), 32'h2);
    end
    wr(ADDR_CTRL, 32'h1);
    repeat (6) @(posedge clock_i);
    wr(ADDR_CTRL, 32'h0);
    #1 `CHK("actions", 4'hD, match_o)
    $display("test outputs done");
  endtask

  task automatic t_capture();
    rst();
    u_timer_pins_model.cap_set(3'h2);
    wr(ADDR_TC, 32'h0000_1234);
    wr(ADDR_CCR, 32'h0000_0C35);
    u_timer_pins_model.cap_set(3'h1);
    rchk("cap0", ADDR_CAP0, 32'h0000_1234);
    rchk("cap1", ADDR_CAP0 + 8'h4, 32'h0000_1234);
    rchk("cap2", ADDR_CAP0 + 8'h8, 32'h0);
    rchk("status", ADDR_STATUS, 32'h30);
    $display("test capture done");
  endtask

  task automatic t_clear();
    rst();
    wr(ADDR_PR, 32'h7);
    wr(ADDR_TC, 32'h55);
    wr(ADDR_PC, 32'h1);
    wr(ADDR_CCR, 32'h0000_0A00);
    u_timer_pins_model.cap_set(3'h4);
    rchk("tc", ADDR_TC, 32'h0);
    rchk("pc", ADDR_PC, 32'h0);
    $display("test clear done");
  endtask

  task automatic t_ext();
    rst();
    wr(ADDR_CTRL, 32'h5);
    u_timer_pins_model.burst(5);
    repeat (3) @(posedge clock_i);
    rchk("tc", ADDR_TC, 32'h5);
    // Count edges that arrive while the clock enable is low must be lost
    @(posedge clock_i) ce_i <= 1'h0;
    u_timer_pins_model.burst(2);
    ce_i <= 1'h1;
    rchk("tc frozen", ADDR_TC, 32'h5);
    $display("test counter mode done");
  endtask

  // Period is ten ticks; the new edge waits for the period reset
  task automatic t_pwm();
    logic [7:0] ca;
    logic [7:0] cb;
    ca = 8'h0;
    cb = 8'h0;
    rst();
    wr(ADDR_MATCH0, 32'h9);
    wr(ADDR_MATCH0 + 8'h4, 32'h3);
    wr(ADDR_PWMC, 32'h2);
    wr(ADDR_MCR, 32'h2);
    wr(ADDR_MATCH0 + 8'h4, 32'h6);
    wr(ADDR_CTRL, 32'h1);
    for (int k = 1; k <= 20; k++) begin
      @(posedge clock_i);
      #1;
      if (k <= 10) ca = ca + 8'(match_o[1]);
      else cb = cb + 8'(match_o[1]);
    end
    `CHK("duty old", 8'h6, ca)
    `CHK("duty new", 8'h3, cb)
    `CHK("period out", 1'h0, match_o[0])
    $display("test pwm done");
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    #100000;
    mismatches++;
    test_done();
  end

  initial begin
    n_checks   = 0;
    mismatches = 0;
    clock_i    = 1'h0;
    ce_i       = 1'h1;
    addr_i     = '0;
    wdata_i    = '0;
    wr_i       = 1'h0;
    rd_i       = 1'h0;
    srst_i     = 1'h1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'h0;
    t_reset();
    t_prescale();
    t_match_reset();
    t_continue();
    t_stop();
    t_outputs();
    t_capture();
    t_clear();
    t_ext();
    t_pwm();
    test_done();
  end
endmodule

`default_nettype wire
